// ---- verilog/sflp_consts.svh ----
// Named constants for the one-time region and sector protection command block
`ifndef SFLP_CONSTS_SVH
`define SFLP_CONSTS_SVH

// ==========================================================================
// Instruction codes
`define SFLP_OP_WRITE_ENABLE_COMMAND 8'h06
`define SFLP_OP_OTP_PROG 8'h42
`define SFLP_OP_OTP_READ 8'h4B
`define SFLP_OP_PROT_READ 8'h2B
`define SFLP_OP_PROT_PROG 8'h2F
`define SFLP_OP_VLOCK_RD 8'hFA
`define SFLP_OP_VLOCK_RD_WIDE 8'hE0
`define SFLP_OP_VLOCK_WR 8'hFB
`define SFLP_OP_VLOCK_WR_WIDE 8'hE1
`define SFLP_OP_PLOCK_RD 8'hFC
`define SFLP_OP_PLOCK_RD_WIDE 8'hE2

// ==========================================================================
// Configuration register two fields
`define SFLP_CFG_ADDR32_BIT 7
`define SFLP_CFG_LAT_LSB 0
`define SFLP_CFG_LAT_W 4

// ==========================================================================
// Frame geometry, in bits
`define SFLP_ADDR_NARROW 6'h18
`define SFLP_ADDR_WIDE 6'h20
`define SFLP_ADDR_NONE 6'h00
`define SFLP_OP_BITS 16'h0008
`define SFLP_PROT_BITS 13'h0010
`define SFLP_VLOCK_BITS 13'h0008

// ==========================================================================
// Data values and reset values
`define SFLP_PROT_RESET 16'hFFFF
`define SFLP_VLOCK_PROTECT 8'h00
`define SFLP_VLOCK_UNPROTECT 8'hFF
`define SFLP_VLOCK_RESET 1'h1
`define SFLP_ERASED_BYTE 8'hFF

// ==========================================================================
// Timing
`define SFLP_MCLK_MHZ 125
`define SFLP_PROG_TIME_NS 100000

`endif

// ---- verilog/sflp_pkg.sv ----
// Types and shared decode functions for the protection command block
package sflp_pkg;
  `include "sflp_consts.svh"

  // ========================================================================
  // Self-timed operation states
  typedef enum logic [1:0]
  {
    SFLP_IDLE = 2'b01,
    SFLP_BUSY = 2'b10
  } sflp_state_t;

  // ========================================================================
  // Decode helpers
  function automatic logic sflp_is_read(input logic [7:0] op);
    sflp_is_read = (op == `SFLP_OP_OTP_READ) || (op == `SFLP_OP_PROT_READ) ||
      (op == `SFLP_OP_VLOCK_RD) || (op == `SFLP_OP_VLOCK_RD_WIDE) ||
      (op == `SFLP_OP_PLOCK_RD) || (op == `SFLP_OP_PLOCK_RD_WIDE);
  endfunction

  function automatic logic [5:0] sflp_addr_bits(input logic [7:0] op,
                                                input logic wide_cfg);
    if ((op == `SFLP_OP_VLOCK_RD_WIDE) || (op == `SFLP_OP_VLOCK_WR_WIDE) ||
        (op == `SFLP_OP_PLOCK_RD_WIDE))
      sflp_addr_bits = `SFLP_ADDR_WIDE;
    else if ((op == `SFLP_OP_OTP_PROG) || (op == `SFLP_OP_OTP_READ) ||
             (op == `SFLP_OP_VLOCK_RD) || (op == `SFLP_OP_VLOCK_WR) ||
             (op == `SFLP_OP_PLOCK_RD))
      sflp_addr_bits = wide_cfg ? `SFLP_ADDR_WIDE : `SFLP_ADDR_NARROW;
    else
      sflp_addr_bits = `SFLP_ADDR_NONE;
  endfunction

  function automatic logic [3:0] sflp_dummy(input logic [7:0] op,
                                            input logic [3:0] lat);
    sflp_dummy = (op == `SFLP_OP_OTP_READ) ? lat : 4'h0;
  endfunction
endpackage

// ---- verilog/sflp_sync.sv ----
// Two-flop level synchroniser
`timescale 1ns/10ps
module sflp_sync
#(
  parameter int WIDTH = 1,
  parameter logic RESET_VAL = 1'b0
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage;

  // ========================================================================
  // First stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stage <= {WIDTH{RESET_VAL}};
      level_out <= {WIDTH{RESET_VAL}};
    end
    else
    begin
      stage <= level_in;
      level_out <= stage;
    end
  end
endmodule

// ---- verilog/sflp_cmd.sv ----
// One-time region and sector protection command handling behind the serial link
`timescale 1ns/10ps
`include "sflp_consts.svh"
module sflp_cmd
  import sflp_pkg::*;
#(
  parameter int OTP_BYTES = 1024,
  parameter int OTP_REGIONS = 16,
  parameter int SECTORS = 256,
  parameter int SECTOR_SHIFT = 18,
  parameter int BUF_BYTES = 16,
  parameter int PROG_CYCLES = (`SFLP_PROG_TIME_NS * `SFLP_MCLK_MHZ + 999) / 1000
)
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  input wire logic [7:0] configuration_register_two_in,
  input wire logic quad_instruction_mode_in,
  input wire logic [SECTORS-1:0] persistent_sector_lock_in,
  input wire logic [OTP_REGIONS-1:0] onetime_region_locked_in,
  input wire logic program_error_clear_in,
  output logic write_in_progress_out,
  output logic write_enable_latch_out,
  output logic program_error_out,
  output logic [15:0] protection_register_out
);
  localparam int OTP_AW = $clog2(OTP_BYTES);
  localparam int SEC_W = $clog2(SECTORS);
  localparam int REG_SHIFT = $clog2(OTP_BYTES / OTP_REGIONS);
  localparam int TMR_W = $clog2(PROG_CYCLES + 1);

  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [15:0] shift;
    logic [12:0] wbits;
    logic frame_tog;
    logic [BUF_BYTES-1:0][7:0] buffer;
  } sflp_rise_t;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } sflp_fall_t;

  typedef struct packed {
    sflp_state_t state;
    logic [TMR_W-1:0] timer;
    logic write_enable_latch;
    logic perr;
    logic [15:0] prot;
    logic [SECTORS-1:0] vlock;
    logic [OTP_BYTES-1:0][7:0] otp;
    logic cs_prev;
    logic seen_tog;
  } sflp_core_t;

  sflp_rise_t rise;
  sflp_rise_t next_rise;
  sflp_fall_t fall;
  sflp_fall_t next_fall;
  sflp_core_t core;
  sflp_core_t next_core;
  logic [15:0] link_cnt;
  logic link_clr;
  logic cs_sync;
  logic quad;
  logic [15:0] op_clk;
  logic [15:0] addr_end;
  logic [15:0] data_start;

  function automatic logic [SEC_W-1:0] sflp_sector(input logic [31:0] a);
    sflp_sector = a[SECTOR_SHIFT +: SEC_W];
  endfunction

  // ========================================================================
  // Frame geometry, shared by both link edges
  assign quad = quad_instruction_mode_in;
  assign link_clr = rst_in | cs_n_in;

  always_comb
  begin
    logic [5:0] alen;
    logic [3:0] lat;
    alen = sflp_addr_bits(rise.opcode,
      configuration_register_two_in[`SFLP_CFG_ADDR32_BIT]);
    lat = sflp_dummy(rise.opcode,
      configuration_register_two_in[`SFLP_CFG_LAT_LSB +: `SFLP_CFG_LAT_W]);
    op_clk = quad ? 16'(`SFLP_OP_BITS >> 2) : `SFLP_OP_BITS;
    addr_end = op_clk + (quad ? 16'(alen >> 2) : 16'(alen));
    data_start = addr_end + 16'(lat);
  end

  // ========================================================================
  // Link receive side, rising edge of the serial clock
  // Clock count clears with chip select; captured fields stay for the core
  always_ff @(posedge sck_in or posedge link_clr)
  begin
    if (link_clr)
      link_cnt <= 16'h0000;
    else if (link_cnt != 16'hFFFF)
      link_cnt <= link_cnt + 16'h0001;
  end

  always_comb
  begin
    logic [12:0] nbits;
    logic [12:0] nbyte;
    next_rise = rise;
    nbits = rise.wbits;
    nbyte = 13'h0000;
    if (link_cnt == 16'h0000)
    begin
      next_rise.addr = 32'h0000_0000;
      next_rise.wbits = 13'h0000;
      next_rise.frame_tog = ~rise.frame_tog;
      nbits = 13'h0000;
    end
    if (link_cnt < op_clk)
      next_rise.opcode = quad ? {rise.opcode[3:0], io_in} : {rise.opcode[6:0], io_in[0]};
    else if (link_cnt < addr_end)
      next_rise.addr = quad ? {rise.addr[27:0], io_in} : {rise.addr[30:0], io_in[0]};
    else if ((link_cnt >= data_start) && !sflp_is_read(rise.opcode))
    begin
      next_rise.shift = quad ? {rise.shift[11:0], io_in} : {rise.shift[14:0], io_in[0]};
      if (nbits != 13'h1FFF)
      begin
        nbits = nbits + (quad ? 13'h0004 : 13'h0001);
        next_rise.wbits = nbits;
      end
      nbyte = (nbits >> 3) - 13'h0001;
      if ((nbits[2:0] == 3'h0) && (nbyte < 13'(BUF_BYTES)))
        next_rise.buffer[nbyte] = next_rise.shift[7:0];
    end
  end

  always_ff @(posedge sck_in or posedge rst_in)
  begin
    if (rst_in)
      rise <= '0;
    else if (!cs_n_in)
      rise <= next_rise;
  end

  // ========================================================================
  // Link transmit side, falling edge of the serial clock
  // Array contents are read without a crossing; reads during busy are undefined
  function automatic logic [7:0] sflp_read_byte(input logic [7:0] op,
                                                input logic [31:0] a,
                                                input logic [15:0] idx);
    logic [16:0] oaddr;
    oaddr = 17'(a[OTP_AW-1:0]) + 17'(idx);
    sflp_read_byte = `SFLP_ERASED_BYTE;
    if (op == `SFLP_OP_PROT_READ)
      sflp_read_byte = idx[0] ? core.prot[15:8] : core.prot[7:0];
    else if ((op == `SFLP_OP_VLOCK_RD) || (op == `SFLP_OP_VLOCK_RD_WIDE))
      sflp_read_byte = {8{core.vlock[sflp_sector(a)]}};
    else if ((op == `SFLP_OP_PLOCK_RD) || (op == `SFLP_OP_PLOCK_RD_WIDE))
      sflp_read_byte = {8{persistent_sector_lock_in[sflp_sector(a)]}};
    else if ((op == `SFLP_OP_OTP_READ) && (oaddr < 17'(OTP_BYTES)))
      sflp_read_byte = core.otp[oaddr[OTP_AW-1:0]];
  endfunction

  always_comb
  begin
    logic [15:0] d;
    logic [7:0] rbyte;
    next_fall = '0;
    d = link_cnt - data_start;
    rbyte = sflp_read_byte(rise.opcode, rise.addr, quad ? (d >> 1) : (d >> 3));
    if ((link_cnt >= op_clk) && (link_cnt >= data_start) && sflp_is_read(rise.opcode))
    begin
      if (quad)
      begin
        next_fall.out = d[0] ? rbyte[3:0] : rbyte[7:4];
        next_fall.oe = 4'hF;
      end
      else
      begin
        next_fall.out = {2'h0, rbyte[3'h7 - d[2:0]], 1'h0};
        next_fall.oe = 4'h2;
      end
    end
  end

  always_ff @(negedge sck_in or posedge link_clr)
  begin
    if (link_clr)
      fall <= '0;
    else
      fall <= next_fall;
  end

  assign io_out = fall.out;
  assign io_oe_out = fall.oe;

  // ========================================================================
  // Core side: frame end taken after chip select is synchronised
  sflp_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_cs_sync (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .level_in(cs_n_in),
    .level_out(cs_sync)
  );

  logic frame_end;
  logic wr_ok;
  logic acc_write_enable_command;
  logic acc_otp;
  logic acc_prot;
  logic acc_vlock;
  logic otp_fail;

  always_comb
  begin
    logic [16:0] oi;
    logic [7:0] vdata;
    oi = 17'h00000;
    vdata = 8'h00;
    next_core = core;
    next_core.cs_prev = cs_sync;
    // Frame counts only if its first clock edge was seen
    frame_end = cs_sync && !core.cs_prev && (rise.frame_tog != core.seen_tog);
    if (frame_end)
      next_core.seen_tog = rise.frame_tog;
    wr_ok = frame_end && core.write_enable_latch && (core.state == SFLP_IDLE);
    acc_write_enable_command = frame_end && (rise.opcode == `SFLP_OP_WRITE_ENABLE_COMMAND) && (rise.wbits == 13'h0000) &&
      (data_start == op_clk) && (core.state == SFLP_IDLE);
    acc_otp = wr_ok && (rise.opcode == `SFLP_OP_OTP_PROG) && (rise.wbits != 13'h0000) &&
      (rise.wbits[2:0] == 3'h0);
    acc_prot = wr_ok && (rise.opcode == `SFLP_OP_PROT_PROG) &&
      (rise.wbits == `SFLP_PROT_BITS);
    acc_vlock = wr_ok && ((rise.opcode == `SFLP_OP_VLOCK_WR) ||
      (rise.opcode == `SFLP_OP_VLOCK_WR_WIDE)) && (rise.wbits == `SFLP_VLOCK_BITS);
    otp_fail = 1'b0;
    for (int i = 0; i < BUF_BYTES; i++)
    begin
      oi = 17'(rise.addr[OTP_AW-1:0]) + 17'(i);
      if ((13'(i) < (rise.wbits >> 3)) && (oi < 17'(OTP_BYTES)) &&
          onetime_region_locked_in[oi[OTP_AW-1:REG_SHIFT]] &&
          (rise.buffer[i] != `SFLP_ERASED_BYTE))
        otp_fail = 1'b1;
    end
    // Clear first so a failing program in the same cycle still sets the flag
    if (program_error_clear_in)
      next_core.perr = 1'b0;
    if (acc_write_enable_command)
      next_core.write_enable_latch = 1'b1;
    if (acc_otp)
    begin
      if (otp_fail)
        next_core.perr = 1'b1;
      else
      begin
        for (int i = 0; i < BUF_BYTES; i++)
        begin
          oi = 17'(rise.addr[OTP_AW-1:0]) + 17'(i);
          if ((13'(i) < (rise.wbits >> 3)) && (oi < 17'(OTP_BYTES)))
            next_core.otp[oi[OTP_AW-1:0]] =
              core.otp[oi[OTP_AW-1:0]] & rise.buffer[i];
        end
      end
    end
    if (acc_prot)
      next_core.prot = core.prot & {rise.shift[7:0], rise.shift[15:8]};
    vdata = rise.shift[7:0];
    if (acc_vlock && (vdata == `SFLP_VLOCK_PROTECT))
      next_core.vlock[sflp_sector(rise.addr)] = 1'b0;
    else if (acc_vlock && (vdata == `SFLP_VLOCK_UNPROTECT))
      next_core.vlock[sflp_sector(rise.addr)] = 1'b1;
    case (core.state)
      SFLP_IDLE:
      begin
        if (acc_otp || acc_prot || acc_vlock)
        begin
          next_core.state = SFLP_BUSY;
          next_core.timer = TMR_W'(PROG_CYCLES - 1);
        end
      end
      SFLP_BUSY:
      begin
        if (core.timer == '0)
        begin
          next_core.state = SFLP_IDLE;
          next_core.write_enable_latch = 1'b0;
        end
        else
          next_core.timer = core.timer - TMR_W'(1);
      end
      default:
      begin
        next_core.state = SFLP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      core <= '0;
      core.state <= SFLP_IDLE;
      core.prot <= `SFLP_PROT_RESET;
      core.vlock <= {SECTORS{`SFLP_VLOCK_RESET}};
      core.otp <= {OTP_BYTES{`SFLP_ERASED_BYTE}};
      core.cs_prev <= 1'b1;
    end
    else
      core <= next_core;
  end

  assign write_in_progress_out = (core.state == SFLP_BUSY);
  assign write_enable_latch_out = core.write_enable_latch;
  assign program_error_out = core.perr;
  assign protection_register_out = core.prot;

  // ========================================================================
  // Checks
  logic [TMR_W:0] ast_busy_len;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      ast_busy_len <= '0;
    else if (write_in_progress_out)
      ast_busy_len <= ast_busy_len + (TMR_W+1)'(1);
    else
      ast_busy_len <= '0;
  end

  AST_BUSY_LENGTH: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(write_in_progress_out) |-> (int'(ast_busy_len) == PROG_CYCLES))
    else $error("busy time differs from program time");
  AST_LATCH_CLEARS: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(write_in_progress_out) |-> !write_enable_latch_out)
    else $error("write enable latch still set after busy");
  AST_NEEDS_LATCH: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(write_in_progress_out) |-> $past(write_enable_latch_out))
    else $error("write started without write enable latch");
  AST_LOCKED_ZERO_FAILS: assert property (@(posedge mclk_in) disable iff (rst_in)
    (acc_otp && otp_fail) |=> (program_error_out && write_in_progress_out))
    else $error("locked region program did not flag error");
  AST_ONES_NO_ERROR: assert property (@(posedge mclk_in) disable iff (rst_in)
    (acc_otp && !otp_fail && !program_error_out) |=> !program_error_out)
    else $error("error flag set by legal program");
  AST_PROT_ONLY_CLEARS: assert property (@(posedge mclk_in) disable iff (rst_in)
    $changed(protection_register_out) |->
      ((protection_register_out & ~$past(protection_register_out)) == 16'h0000) &&
      $rose(write_in_progress_out))
    else $error("protection register changed outside a program");
  AST_VLOCK_TIMED: assert property (@(posedge mclk_in) disable iff (rst_in)
    $changed(core.vlock) |-> $rose(write_in_progress_out) ##1 write_in_progress_out[*4])
    else $error("volatile lock changed without timed write");
  AST_DRIVE_ONLY_READS: assert property (@(negedge sck_in) disable iff (link_clr)
    (io_oe_out != 4'h0) |-> sflp_is_read(rise.opcode))
    else $error("data lines driven outside a read");
  COV_OTP_PROG: cover property (@(posedge mclk_in) disable iff (rst_in) acc_otp && !otp_fail);
  COV_OTP_FAIL: cover property (@(posedge mclk_in) disable iff (rst_in) acc_otp && otp_fail);
  COV_PROT_PROG: cover property (@(posedge mclk_in) disable iff (rst_in) acc_prot);
  COV_VLOCK_WR: cover property (@(posedge mclk_in) disable iff (rst_in) acc_vlock);
endmodule

// ---- verification/sflp_host.sv ----
// Behavioural SPI host that frames flash commands on the serial link
`timescale 1ns/10ps
module sflp_host
(
  input wire logic quad_in,
  input wire logic [3:0] io_line_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic [3:0] io_drv_out
);
  logic [63:0] rx_bits;

  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    io_drv_out = 4'h0;
    rx_bits = 64'h0;
  end

  // ==========================================================================
  // One frame: ntx bits out MSB first, then nrx bits read back
  // Clock stands still outside frames; a released line toggles so no stale level
  task automatic frame(input logic [127:0] tx, input int ntx, input int nrx);
    int w;
    int k;
    w = quad_in ? 4 : 1;
    rx_bits = 64'h0;
    #1.7;
    cs_n_out = 1'b0;
    for (k = 0; k < (ntx + nrx) / w; k++)
    begin
      if (k * w >= ntx)
        io_drv_out = ~io_drv_out;
      else if (quad_in)
        io_drv_out = tx[ntx-1-4*k -: 4];
      else
        io_drv_out = {~io_drv_out[3:1], tx[ntx-1-k]};
      #3;
      if (k * w >= ntx)
        rx_bits = quad_in ? {rx_bits[59:0], io_line_in} : {rx_bits[62:0], io_line_in[1]};
      sck_out = 1'b1;
      #3;
      sck_out = 1'b0;
    end
    // Release straight after the last bit, so writes are taken whole
    #1;
    cs_n_out = 1'b1;
    io_drv_out = ~io_drv_out;
    // Gap of about five core cycles between frames
    #40;
  endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the protection and one-time region command block
`timescale 1ns/10ps
`include "sflp_consts.svh"
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module testbench;
  localparam int PROG = 20;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b0;
  logic [7:0] cfg = 8'h00;
  logic quad = 1'b0;
  logic [255:0] plock = {256{1'b1}};
  logic [15:0] otp_lock = 16'h0000;
  logic perr_clr = 1'b0;
  logic sck;
  logic cs_n;
  logic [3:0] host_io;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [3:0] io_line;
  logic write_in_progress;
  logic write_enable_latch;
  logic perr;
  logic [15:0] prot;
  logic [63:0] rx;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;

  assign io_line = (io_oe & io_out) | (~io_oe & host_io);

  sflp_cmd #(.PROG_CYCLES(PROG)) i_sflp_cmd (.mclk_in(mclk_in), .rst_in(rst_in), .sck_in(sck),
    .cs_n_in(cs_n), .io_in(io_line), .io_out(io_out), .io_oe_out(io_oe),
    .configuration_register_two_in(cfg), .quad_instruction_mode_in(quad),
    .persistent_sector_lock_in(plock), .onetime_region_locked_in(otp_lock),
    .program_error_clear_in(perr_clr), .write_in_progress_out(write_in_progress),
    .write_enable_latch_out(write_enable_latch), .program_error_out(perr), .protection_register_out(prot));

  sflp_host i_sflp_host (.quad_in(quad), .io_line_in(io_line), .sck_out(sck),
    .cs_n_out(cs_n), .io_drv_out(host_io));

  always #4 mclk_in = ~mclk_in;

  // ==========================================================================
  // Verdict and hang guard
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Link access helpers
  // Busy length counted from its first cycle; the count runs on its own, so the host's gap after a frame does not shorten it
  int busy_run = 0;
  int busy_last = 0;

  always @(negedge mclk_in)
  begin
    if (write_in_progress === 1'b1)
      busy_run++;
    else if (busy_run != 0)
    begin
      busy_last = busy_run;
      busy_run = 0;
    end
  end

  task automatic wait_done(output int cnt);
    busy_last = 0;
    for (int t = 0; t < 40 && write_in_progress !== 1'b1; t++)
      @(negedge mclk_in);
    for (int t = 0; t < 200 && write_in_progress === 1'b1; t++)
      @(negedge mclk_in);
    @(posedge mclk_in);
    cnt = busy_last;
  endtask

  task automatic rd(input logic [127:0] tx, input int ntx, input int nrx);
    i_sflp_host.frame(tx, ntx, nrx);
    rx = i_sflp_host.rx_bits;
  endtask

  // Write enable first, then the write frame
  task automatic prog(input logic [127:0] tx, input int ntx, output int cnt);
    i_sflp_host.frame(128'(`SFLP_OP_WRITE_ENABLE_COMMAND), 8, 0);
    i_sflp_host.frame(tx, ntx, 0);
    wait_done(cnt);
  endtask

  // Looked at early: a wrongly started write would still be busy here
  task automatic idle_wip(input string nm);
    @(negedge mclk_in);
    `CHK(nm, 1'b0, write_in_progress)
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    plock[5] = 1'b0;
    // Raised on an edge so the link-side flops see a reset event
    @(negedge mclk_in);
    rst_in = 1'b1;
    repeat (12) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    `CHK("prot_reset", 16'hFFFF, prot)
    `CHK("wel_reset", 1'b0, write_enable_latch)
    i_sflp_host.frame(128'({8'h2F, 16'h5AC3}), 24, 0);
    idle_wip("wip_no_wel");
    `CHK("prot_no_wel", 16'hFFFF, prot)
    i_sflp_host.frame(128'(`SFLP_OP_WRITE_ENABLE_COMMAND), 8, 0);
    `CHK("wel_set", 1'b1, write_enable_latch)
    i_sflp_host.frame(128'({8'h2F, 16'h5AC3}), 24, 0);
    wait_done(n);
    `CHK("prot_wip_time", PROG, n)
    `CHK("prot_value", 16'hC35A, prot)
    `CHK("prot_wel_clear", 1'b0, write_enable_latch)
    `CHK("prot_perr", 1'b0, perr)
    rd(128'(8'h2B), 8, 32);
    `CHK("prot_read", 32'h5AC35AC3, rx[31:0])
    i_sflp_host.frame(128'(`SFLP_OP_WRITE_ENABLE_COMMAND), 8, 0);
    i_sflp_host.frame(128'({8'h2F, 17'h00000}), 25, 0);
    idle_wip("wip_17_bits");
    `CHK("prot_17_bits", 16'hC35A, prot)
    prog(128'({8'hFB, 24'h0C0000, 8'h00}), 40, n);
    `CHK("vlock_wip_time", PROG, n)
    `CHK("vlock_wel_clear", 1'b0, write_enable_latch)
    rd(128'({8'hFA, 24'h0C0000}), 32, 16);
    `CHK("vlock_read", 16'h0000, rx[15:0])
    rd(128'({8'hE0, 32'h00100000}), 40, 8);
    `CHK("vlock_other", 8'hFF, rx[7:0])
    @(negedge mclk_in);
    quad = 1'b1;
    cfg = 8'h80;
    prog(128'({8'hE1, 32'h000C0000, 8'hFF}), 48, n);
    `CHK("quad_wip_time", PROG, n)
    rd(128'({8'hFA, 32'h000C0000}), 40, 16);
    `CHK("quad_vlock_read", 16'hFFFF, rx[15:0])
    @(negedge mclk_in);
    quad = 1'b0;
    cfg = 8'h00;
    rd(128'({8'hFC, 24'h140000}), 32, 16);
    `CHK("plock_read", 16'h0000, rx[15:0])
    rd(128'({8'hE2, 32'h00180000}), 40, 16);
    `CHK("plock_wide", 16'hFFFF, rx[15:0])
    @(negedge mclk_in);
    cfg = 8'h04;
    prog(128'({8'h42, 24'h000010, 16'hA53C}), 48, n);
    `CHK("otp_wip_time", PROG, n)
    rd(128'({8'h4B, 24'h000010, 4'h0}), 36, 16);
    `CHK("otp_read", 16'hA53C, rx[15:0])
    prog(128'({8'h42, 24'h000010, 8'h0F}), 40, n);
    rd(128'({8'h4B, 24'h000010, 4'h0}), 36, 16);
    `CHK("otp_reprogram", 16'h053C, rx[15:0])
    prog(128'({8'h42, 24'h000000, 8'h77}), 40, n);
    prog(128'({8'h42, 24'h0003FF, 16'h1234}), 48, n);
    rd(128'({8'h4B, 24'h0003FF, 4'h0}), 36, 16);
    `CHK("otp_top", 16'h12FF, rx[15:0])
    rd(128'({8'h4B, 24'h000000, 4'h0}), 36, 8);
    `CHK("otp_no_wrap", 8'h77, rx[7:0])
    i_sflp_host.frame(128'({8'h42, 24'h000020, 8'h00}), 40, 0);
    idle_wip("otp_no_wel");
    rd(128'({8'h4B, 24'h000020, 4'h0}), 36, 8);
    `CHK("otp_no_wel_data", 8'hFF, rx[7:0])
    @(negedge mclk_in);
    otp_lock[0] = 1'b1;
    prog(128'({8'h42, 24'h000010, 8'h00}), 40, n);
    `CHK("otp_locked_perr", 1'b1, perr)
    rd(128'({8'h4B, 24'h000010, 4'h0}), 36, 16);
    `CHK("otp_locked_data", 16'h053C, rx[15:0])
    @(negedge mclk_in);
    perr_clr = 1'b1;
    @(negedge mclk_in);
    perr_clr = 1'b0;
    @(negedge mclk_in);
    `CHK("perr_cleared", 1'b0, perr)
    prog(128'({8'h42, 24'h000010, 8'hFF}), 40, n);
    `CHK("otp_ones_perr", 1'b0, perr)
    wrap_up();
  end
endmodule
